// ### design/rscu_consts.svh
// constants of the rangefinder serial command unit
// Notes on behaviour
// - default 38400 baud; 9600/57600/115200 selectable
// - characters sent least significant bit first
// - one start, eight data, no parity, one stop
// - enters command-ready state by itself after reset
// - every defined command accepted while ready
// - distance reply only after measurement completes
// - single command: one measurement, then report
// - 1 Hz command repeats until stop
// - 5 Hz command repeats until stop
// - self-test replies temperature and working status
// - reply carries first and last target
// - targets below stored gate are suppressed
// - gate zero disables; never cleared automatically
// - baud command: 55 F6 hi lo check end
// - rate codes 0060/0180/0240/0480 select baud
// - baud reply CC 01 19, echoes code, ends 55
// - reply check is XOR of bytes 2..13, end 55
// - optical status 03 normal, FF abnormal
`ifndef RSCU_CONSTS_SVH
`define RSCU_CONSTS_SVH
`define RSCU_CLK_HZ       125000000
`define RSCU_BAUD_9600    9600
`define RSCU_BAUD_38400   38400
`define RSCU_BAUD_57600   57600
`define RSCU_BAUD_115200  115200
`define RSCU_RATE_1HZ     1
`define RSCU_RATE_5HZ     5
`define RSCU_CODE_9600    16'h0060
`define RSCU_CODE_38400   16'h0180
`define RSCU_CODE_57600   16'h0240
`define RSCU_CODE_115200  16'h0480
`define RSCU_CMD_HEADER   8'h55
`define RSCU_CMD_BAUD     8'hF6
`define RSCU_CMD_SINGLE   8'hA1
`define RSCU_CMD_RUN_1HZ  8'hA2
`define RSCU_CMD_RUN_5HZ  8'hA3
`define RSCU_CMD_STOP     8'hA4
`define RSCU_CMD_SELFTEST 8'hA5
`define RSCU_CMD_GATE     8'hA6
`define RSCU_REP_HEADER   8'hCC
`define RSCU_REP_ADDR     8'h01
`define RSCU_REP_BAUD     8'h19
`define RSCU_REP_RANGE    8'h10
`define RSCU_REP_SELF     8'h20
`define RSCU_REP_END      8'h55
`define RSCU_OPT_NORMAL   8'h03
`define RSCU_OPT_FAULT    8'hFF
`define RSCU_BAUD_ACK     8'h01
`define RSCU_PAYLOAD_LEN  12
`define RSCU_FRAME_LAST   4'd14
`define RSCU_IDX_CHECK    4'd13
`define RSCU_BIT_STOP     4'd9
`endif

// ### design/rscu_pkg.sv
// types of the rangefinder serial command unit
package rscu_pkg;
    typedef enum logic [1:0] {
        RSCU_B9600   = 2'b00,
        RSCU_B38400  = 2'b01,
        RSCU_B57600  = 2'b10,
        RSCU_B115200 = 2'b11
    } rscu_baud_t;
    typedef enum logic [1:0] {
        RSCU_MODE_IDLE = 2'b00,
        RSCU_MODE_1HZ  = 2'b01,
        RSCU_MODE_5HZ  = 2'b10
    } rscu_mode_t;
    typedef enum logic [2:0] {
        RSCU_P_HDR  = 3'b000,
        RSCU_P_CMD  = 3'b001,
        RSCU_P_HI   = 3'b010,
        RSCU_P_LO   = 3'b011,
        RSCU_P_CHK  = 3'b100,
        RSCU_P_END  = 3'b101
    } rscu_parse_t;
endpackage

// ### design/rscu_top.sv
// serial command interpreter: uart, command parser, ranging sequencer, reply framer
`timescale 1ns/1ps
`include "rscu_consts.svh"
module rscu_top import rscu_pkg::*; #(
    parameter int CLK_HZ     = `RSCU_CLK_HZ,
    parameter int PERIOD_1HZ = CLK_HZ / `RSCU_RATE_1HZ,
    parameter int PERIOD_5HZ = CLK_HZ / `RSCU_RATE_5HZ,
    parameter int DIV_9600   = CLK_HZ / `RSCU_BAUD_9600,
    parameter int DIV_38400  = CLK_HZ / `RSCU_BAUD_38400,
    parameter int DIV_57600  = CLK_HZ / `RSCU_BAUD_57600,
    parameter int DIV_115200 = CLK_HZ / `RSCU_BAUD_115200
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        rx_pin,
    output logic             tx_pin,
    output logic             meas_start,
    input  wire logic        meas_done,
    input  wire logic [7:0]  meas_status,
    input  wire logic [15:0] meas_first,
    input  wire logic [15:0] meas_last,
    input  wire logic [7:0]  self_status,
    input  wire logic [7:0]  self_temp,
    input  wire logic        self_optical_ok,
    input  wire logic [15:0] self_exposures,
    output logic [15:0]      gate_value,
    output logic [15:0]      baud_code,
    output logic [1:0]       ranging_mode,
    output logic             tx_busy
);
    // ---------------- baud selection
    rscu_baud_t baud_sel;
    rscu_baud_t baud_pend;
    logic [31:0] bit_div;

    always_comb begin
        unique case (baud_sel)
            RSCU_B9600:   bit_div = DIV_9600;
            RSCU_B38400:  bit_div = DIV_38400;
            RSCU_B57600:  bit_div = DIV_57600;
            RSCU_B115200: bit_div = DIV_115200;
        endcase
    end

    // ---------------- receiver
    logic        rx_s1;
    logic        rx_s2;
    logic        rx_act;
    logic [3:0]  rx_bit;
    logic [31:0] rx_cnt;
    logic [7:0]  rx_shift;
    logic        rx_valid;
    logic [7:0]  rx_byte;

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
        end else begin
            rx_s1 <= rx_pin;
            rx_s2 <= rx_s1;
        end
    end

    // samples mid-bit: half a bit after the start edge, then a whole bit apart
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_act   <= 1'b0;
            rx_bit   <= 4'd0;
            rx_cnt   <= 32'd0;
            rx_shift <= 8'h00;
            rx_valid <= 1'b0;
            rx_byte  <= 8'h00;
        end else begin
            rx_valid <= 1'b0;
            if (!rx_act) begin
                if (!rx_s2) begin
                    rx_act <= 1'b1;
                    rx_bit <= 4'd0;
                    rx_cnt <= bit_div >> 1;
                end
            end else if (rx_cnt != 32'd0) begin
                rx_cnt <= rx_cnt - 32'd1;
            end else begin
                rx_cnt <= bit_div - 32'd1;
                rx_bit <= rx_bit + 4'd1;
                if (rx_bit == 4'd0) begin
                    if (rx_s2) rx_act <= 1'b0;
                end else if (rx_bit == `RSCU_BIT_STOP) begin
                    rx_act <= 1'b0;
                    if (rx_s2) begin
                        rx_valid <= 1'b1;
                        rx_byte  <= rx_shift;
                    end
                end else begin
                    rx_shift <= {rx_s2, rx_shift[7:1]};
                end
            end
        end
    end

    // ---------------- command parser
    rscu_parse_t pstate;
    logic [7:0]  c_cmd;
    logic [7:0]  c_hi;
    logic [7:0]  c_lo;
    logic        c_ok;
    logic        cmd_go;

    always_ff @(posedge clk) begin
        if (rst) begin
            pstate <= RSCU_P_HDR;
            c_cmd  <= 8'h00;
            c_hi   <= 8'h00;
            c_lo   <= 8'h00;
            c_ok   <= 1'b0;
            cmd_go <= 1'b0;
        end else begin
            cmd_go <= 1'b0;
            if (rx_valid) begin
                unique case (pstate)
                    RSCU_P_HDR: if (rx_byte == `RSCU_CMD_HEADER) pstate <= RSCU_P_CMD;
                    RSCU_P_CMD: begin
                        c_cmd  <= rx_byte;
                        pstate <= RSCU_P_HI;
                    end
                    RSCU_P_HI: begin
                        c_hi   <= rx_byte;
                        pstate <= RSCU_P_LO;
                    end
                    RSCU_P_LO: begin
                        c_lo   <= rx_byte;
                        pstate <= RSCU_P_CHK;
                    end
                    RSCU_P_CHK: begin
                        c_ok   <= (rx_byte == (c_cmd ^ c_hi ^ c_lo));
                        pstate <= RSCU_P_END;
                    end
                    RSCU_P_END: begin
                        // final byte is not checked; any value closes the frame
                        cmd_go <= c_ok;
                        pstate <= RSCU_P_HDR;
                    end
                    default: pstate <= RSCU_P_HDR;
                endcase
            end
        end
    end

    wire logic [15:0] c_param = {c_hi, c_lo};
    wire logic do_single = cmd_go && (c_cmd == `RSCU_CMD_SINGLE);
    wire logic do_1hz    = cmd_go && (c_cmd == `RSCU_CMD_RUN_1HZ);
    wire logic do_5hz    = cmd_go && (c_cmd == `RSCU_CMD_RUN_5HZ);
    wire logic do_stop   = cmd_go && (c_cmd == `RSCU_CMD_STOP);
    wire logic do_self   = cmd_go && (c_cmd == `RSCU_CMD_SELFTEST);
    wire logic do_gate   = cmd_go && (c_cmd == `RSCU_CMD_GATE);
    wire logic do_baud   = cmd_go && (c_cmd == `RSCU_CMD_BAUD);
    logic       code_ok;
    rscu_baud_t code_sel;
    always_comb begin
        code_ok  = 1'b1;
        code_sel = RSCU_B38400;
        unique case (c_param)
            `RSCU_CODE_9600:   code_sel = RSCU_B9600;
            `RSCU_CODE_38400:  code_sel = RSCU_B38400;
            `RSCU_CODE_57600:  code_sel = RSCU_B57600;
            `RSCU_CODE_115200: code_sel = RSCU_B115200;
            default:           code_ok  = 1'b0;
        endcase
    end

    // gate survives every other command; only a new gate write changes it
    always_ff @(posedge clk) begin
        if (rst) gate_value <= 16'h0000;
        else if (do_gate) gate_value <= c_param;
    end

    // ---------------- ranging sequencer
    rscu_mode_t  mode;
    logic [31:0] per_cnt;
    logic        meas_busy;
    logic        fire;
    assign ranging_mode = mode;
    assign fire = !meas_busy && (do_single || ((mode != RSCU_MODE_IDLE) && (per_cnt == 32'd0)));
    always_ff @(posedge clk) begin
        if (rst) begin
            mode    <= RSCU_MODE_IDLE;
            per_cnt <= 32'd0;
        end else if (do_stop || do_single) begin
            mode    <= RSCU_MODE_IDLE;
            per_cnt <= 32'd0;
        end else if (do_1hz) begin
            mode    <= RSCU_MODE_1HZ;
            per_cnt <= 32'd0;
        end else if (do_5hz) begin
            mode    <= RSCU_MODE_5HZ;
            per_cnt <= 32'd0;
        end else if (mode != RSCU_MODE_IDLE) begin
            if (per_cnt == 32'd0)
                per_cnt <= (mode == RSCU_MODE_1HZ) ? PERIOD_1HZ - 1 : PERIOD_5HZ - 1;
            else
                per_cnt <= per_cnt - 32'd1;
        end
    end

    // a tick that lands while the core is still busy is skipped, not queued
    always_ff @(posedge clk) begin
        if (rst) begin
            meas_start <= 1'b0;
            meas_busy  <= 1'b0;
        end else begin
            meas_start <= fire;
            if (fire) meas_busy <= 1'b1;
            else if (meas_done) meas_busy <= 1'b0;
        end
    end

    // ---------------- pending replies (a new event wins over the take)
    logic        pend_rng;
    logic        pend_self;
    logic        pend_baud;
    logic [7:0]  res_status;
    logic [15:0] res_first;
    logic [15:0] res_last;
    logic [15:0] baud_echo;
    logic        take;
    logic        take_baud;
    logic        take_self;
    function automatic logic [15:0] gated(input logic [15:0] d, input logic [15:0] g);
        gated = ((g != 16'h0000) && (d < g)) ? 16'h0000 : d;
    endfunction

    always_ff @(posedge clk) begin
        if (rst) begin
            res_status <= 8'h00;
            res_first  <= 16'h0000;
            res_last   <= 16'h0000;
        end else if (meas_done && meas_busy) begin
            res_status <= meas_status;
            res_first  <= gated(meas_first, gate_value);
            res_last   <= gated(meas_last, gate_value);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pend_rng  <= 1'b0;
            pend_self <= 1'b0;
            pend_baud <= 1'b0;
            baud_pend <= RSCU_B38400;
            baud_echo <= `RSCU_CODE_38400;
        end else begin
            pend_rng  <= (pend_rng && !(take && !take_baud && !take_self)) || (meas_done && meas_busy);
            pend_self <= (pend_self && !take_self) || do_self;
            pend_baud <= (pend_baud && !take_baud) || (do_baud && code_ok);
            if (do_baud && code_ok) begin
                baud_pend <= code_sel;
                baud_echo <= c_param;
            end
        end
    end

    // ---------------- reply framer and transmitter
    logic [7:0]  pay [0:`RSCU_PAYLOAD_LEN-1];
    logic [7:0]  next_pay [0:`RSCU_PAYLOAD_LEN-1];
    logic [7:0]  chk;
    logic [7:0]  next_chk;
    logic        frame_baud;
    logic [3:0]  tx_idx;
    logic [3:0]  tx_bit;
    logic [31:0] tx_cnt;
    logic [7:0]  tx_byte;
    assign take      = !tx_busy && (pend_rng || pend_self || pend_baud);
    assign take_baud = take && pend_baud;
    assign take_self = take && !pend_baud && pend_self;
    assign baud_code = baud_echo;

    always_comb begin
        for (int i = 0; i < `RSCU_PAYLOAD_LEN; i++) next_pay[i] = 8'h00;
        next_pay[0] = `RSCU_REP_ADDR;
        if (pend_baud) begin
            next_pay[1] = `RSCU_REP_BAUD;
            next_pay[3] = `RSCU_BAUD_ACK;
            next_pay[6] = baud_echo[15:8];
            next_pay[7] = baud_echo[7:0];
        end else if (pend_self) begin
            next_pay[1]  = `RSCU_REP_SELF;
            next_pay[2]  = self_status;
            next_pay[3]  = self_temp;
            next_pay[4]  = self_optical_ok ? `RSCU_OPT_NORMAL : `RSCU_OPT_FAULT;
            next_pay[5]  = gate_value[15:8];
            next_pay[6]  = gate_value[7:0];
            next_pay[7]  = baud_echo[15:8];
            next_pay[8]  = baud_echo[7:0];
            next_pay[9]  = self_exposures[15:8];
            next_pay[10] = self_exposures[7:0];
        end else begin
            next_pay[1] = `RSCU_REP_RANGE;
            next_pay[2] = res_status;
            next_pay[3] = res_first[15:8];
            next_pay[4] = res_first[7:0];
            next_pay[5] = res_last[15:8];
            next_pay[6] = res_last[7:0];
        end
        next_chk = 8'h00;
        for (int i = 0; i < `RSCU_PAYLOAD_LEN; i++) next_chk = next_chk ^ next_pay[i];
    end

    always_comb begin
        if (tx_idx == 4'd0) tx_byte = `RSCU_REP_HEADER;
        else if (tx_idx == `RSCU_IDX_CHECK) tx_byte = chk;
        else if (tx_idx == `RSCU_FRAME_LAST) tx_byte = `RSCU_REP_END;
        else tx_byte = pay[tx_idx - 4'd1];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < `RSCU_PAYLOAD_LEN; i++) pay[i] <= 8'h00;
            chk        <= 8'h00;
            frame_baud <= 1'b0;
        end else if (take) begin
            for (int i = 0; i < `RSCU_PAYLOAD_LEN; i++) pay[i] <= next_pay[i];
            chk        <= next_chk;
            frame_baud <= pend_baud;
        end
    end

    // bit 0 start, 1..8 data lsb first, 9 stop, 10 one idle cycle held high before the next start
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_busy  <= 1'b0;
            tx_idx   <= 4'd0;
            tx_bit   <= 4'd0;
            tx_cnt   <= 32'd0;
            tx_pin   <= 1'b1;
            baud_sel <= RSCU_B38400;
        end else if (!tx_busy) begin
            tx_pin <= 1'b1;
            if (take) begin
                tx_busy <= 1'b1;
                tx_idx  <= 4'd0;
                tx_bit  <= 4'd0;
                tx_cnt  <= 32'd0;
            end
        end else if (tx_cnt != 32'd0) begin
            tx_cnt <= tx_cnt - 32'd1;
        end else begin
            tx_cnt <= bit_div - 32'd1;
            if (tx_bit == 4'd0) tx_pin <= 1'b0;
            else if (tx_bit >= `RSCU_BIT_STOP) tx_pin <= 1'b1;
            else tx_pin <= tx_byte[tx_bit[2:0] - 3'd1];
            if (tx_bit == `RSCU_BIT_STOP + 4'd1) begin
                tx_bit <= 4'd0;
                tx_cnt <= 32'd0;
                if (tx_idx == `RSCU_FRAME_LAST) begin
                    tx_busy <= 1'b0;
                    // old rate held until the stop bit of the last byte has gone
                    if (frame_baud) baud_sel <= baud_pend;
                end else begin
                    tx_idx <= tx_idx + 4'd1;
                end
            end else begin
                tx_bit <= tx_bit + 4'd1;
            end
        end
    end
endmodule // rscu_top

// ### tb/rscu_checker_assertions.sv
// concurrent checks on the ports of the serial command unit
`timescale 1ns/1ps
module rscu_checker import rscu_pkg::*; #(
    parameter int PERIOD_1HZ = 3200,
    parameter int PERIOD_5HZ = 1600,
    parameter int DIV_9600   = 16,
    parameter int DIV_115200 = 4
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        tx_pin,
    input wire logic        meas_start,
    input wire logic [15:0] gate_value,
    input wire logic [15:0] baud_code,
    input wire logic [1:0]  ranging_mode,
    input wire logic        tx_busy
);
    int         busy_cnt;
    int         gap;
    logic [1:0] last_mode;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    always_ff @(posedge clk) begin
        busy_cnt <= (rst || !tx_busy) ? 0 : busy_cnt + 1;
        gap <= (rst || meas_start) ? 1 : gap + 1;
    end
    // forget the previous mode once idle, so a restarted run is not held to the old phase
    always_ff @(posedge clk) begin
        if (rst || ranging_mode == 2'h0) begin
            last_mode <= 2'h0;
        end else if (meas_start) begin
            last_mode <= ranging_mode;
        end
    end

    sequence s_start_bit;
        ##[0:2] !tx_pin ##1 !tx_pin[*3];
    endsequence

    a_reset_state: assert property (disable iff (1'b0) rst |=> tx_pin && !tx_busy && !meas_start &&
        gate_value == 16'h0000 && baud_code == 16'h0180 && ranging_mode == 2'h0)
        else $error("outputs not at reset values");
    a_start_pulse: assert property (meas_start |=> !meas_start)
        else $error("measurement request longer than one cycle");
    a_idle_high: assert property (!tx_busy |-> tx_pin)
        else $error("serial output low while idle");
    a_frame_start: assert property ($rose(tx_busy) |-> s_start_bit)
        else $error("reply frame without start bit");
    a_stop_before_idle: assert property ($fell(tx_busy) |-> $past(tx_pin) && tx_pin)
        else $error("frame ended without stop bit");
    a_frame_length: assert property ($fell(tx_busy) |->
        busy_cnt >= 149 * DIV_115200 && busy_cnt <= 150 * DIV_9600 + 15)
        else $error("reply frame length wrong");
    a_cont_period: assert property (meas_start && ranging_mode != 2'h0 && last_mode == ranging_mode |->
        gap % (ranging_mode == 2'h1 ? PERIOD_1HZ : PERIOD_5HZ) == 0)
        else $error("continuous ranging period wrong");
    a_code_legal: assert property (baud_code inside {16'h0060, 16'h0180, 16'h0240, 16'h0480})
        else $error("rate code outside table");
endmodule // rscu_checker

bind rscu_top rscu_checker #(.PERIOD_1HZ(PERIOD_1HZ), .PERIOD_5HZ(PERIOD_5HZ), .DIV_9600(DIV_9600),
    .DIV_115200(DIV_115200)) u_checker (.clk(clk), .rst(rst), .tx_pin(tx_pin), .meas_start(meas_start),
    .gate_value(gate_value), .baud_code(baud_code), .ranging_mode(ranging_mode), .tx_busy(tx_busy));

// ### tb/rscu_core_model.sv
// ranging core stand-in: answers each measurement request after a fixed latency
`timescale 1ns/1ps
module rscu_core_model #(
    parameter int LAT = 20
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        meas_start,
    input  wire logic [15:0] first_in,
    input  wire logic [15:0] last_in,
    output logic             meas_done,
    output logic [7:0]       meas_status,
    output logic [15:0]      meas_first,
    output logic [15:0]      meas_last
);
    int cnt;

    always_ff @(posedge clk) begin
        cnt <= rst ? 0 : meas_start ? LAT : (cnt > 0 ? cnt - 1 : 0);
    end
    // results hold only in the done cycle; inverted otherwise so stale sampling shows
    assign meas_done   = (cnt == 1);
    assign meas_status = meas_done ? 8'h01 : 8'hFE;
    assign meas_first  = meas_done ? first_in : ~first_in;
    assign meas_last   = meas_done ? last_in : ~last_in;
endmodule // rscu_core_model

// ### tb/rangefinder_serial_command_unit_bench.sv
// self-checking bench: host-side serial tasks against the command unit
`timescale 1ns/1ps
`include "rscu_consts.svh"
module rangefinder_serial_command_unit_bench;
    import rscu_pkg::*;
    typedef logic [7:0] rscu_pay_t [12];
    localparam int P1 = 3200;
    localparam int P5 = 1600;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        rx_pin = 1'b1;
    logic        self_ok = 1'b1;
    logic [7:0]  self_st = 8'h5A;
    logic [7:0]  self_tp = 8'h19;
    logic [15:0] self_ex = 16'h1234;
    logic        tx_pin, tx_busy, meas_start, meas_done;
    logic [7:0]  meas_status;
    logic [15:0] meas_first, meas_last, gate_value, baud_code;
    logic [15:0] first_v = 16'h0080;
    logic [15:0] last_v = 16'h0200;
    logic [1:0]  ranging_mode;
    logic [15:0] codes [4] = '{16'h0060, 16'h0480, 16'h0240, 16'h0180};
    int          divs [4] = '{16, 4, 6, 8};
    int          n_errors = 0, n_checks = 0, div = 8, cyc = 0, starts = 0;

    rscu_top #(.PERIOD_1HZ(P1), .PERIOD_5HZ(P5), .DIV_9600(16), .DIV_38400(8), .DIV_57600(6),
        .DIV_115200(4)) dut (.clk(clk), .rst(rst), .rx_pin(rx_pin), .tx_pin(tx_pin), .meas_start(meas_start),
        .meas_done(meas_done), .meas_status(meas_status), .meas_first(meas_first), .meas_last(meas_last),
        .self_status(self_st), .self_temp(self_tp), .self_optical_ok(self_ok), .self_exposures(self_ex),
        .gate_value(gate_value), .baud_code(baud_code), .ranging_mode(ranging_mode), .tx_busy(tx_busy));
    rscu_core_model #(.LAT(20)) core (.clk(clk), .rst(rst), .meas_start(meas_start), .first_in(first_v),
        .last_in(last_v), .meas_done(meas_done), .meas_status(meas_status), .meas_first(meas_first),
        .meas_last(meas_last));

    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (meas_start === 1'b1) starts++;
        if (cyc == 100000) begin
            n_errors++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_pin = f[i];
            repeat (div) @(negedge clk);
        end
    endtask

    // flip spoils the check byte so the frame must be dropped
    task automatic send_cmd(input logic [7:0] c, input logic [15:0] v, input logic [7:0] flip);
        logic [7:0] fr [6];
        fr = '{8'h55, c, v[15:8], v[7:0], c ^ v[15:8] ^ v[7:0] ^ flip, 8'h00};
        foreach (fr[i]) send_byte(fr[i]);
        // one idle bit time lets the command take effect before the caller looks at outputs
        repeat (div) @(negedge clk);
    endtask

    task automatic get_frame(input rscu_pay_t p);
        logic [7:0] e [15];
        logic [7:0] b;
        int         w;
        e[0] = 8'hCC;
        e[13] = 8'h00;
        e[14] = 8'h55;
        for (int i = 0; i < 12; i++) begin
            e[i + 1] = p[i];
            e[13] ^= p[i];
        end
        foreach (e[k]) begin
            w = 0;
            while (tx_pin !== 1'b0 && w < 20000) begin
                @(negedge clk);
                w++;
            end
            repeat (div / 2) @(negedge clk);
            for (int j = 0; j < 8; j++) begin
                repeat (div) @(negedge clk);
                b[j] = tx_pin;
            end
            repeat (div) @(negedge clk);
            chk({8'h00, b}, {8'h00, e[k]});
            chk({15'h0, tx_pin}, 16'h0001);
        end
    endtask

    task automatic exchange(input logic [7:0] c, input logic [15:0] v, input rscu_pay_t p);
        fork
            send_cmd(c, v, 8'h00);
            get_frame(p);
        join
    endtask

    // waits for 64 quiet cycles so a trailing frame or a rate switch has landed
    task automatic idle();
        int q = 0;
        for (int w = 0; w < 20000 && q < 64; w++) begin
            @(negedge clk);
            q = (tx_busy === 1'b0) ? q + 1 : 0;
        end
    endtask

    function automatic rscu_pay_t self_pay(input logic [7:0] opt, input logic [15:0] code);
        return '{8'h01, 8'h20, self_st, self_tp, opt, 8'h00, 8'h00, code[15:8], code[7:0],
            self_ex[15:8], self_ex[7:0], 8'h00};
    endfunction

    function automatic rscu_pay_t range_pay(input logic [15:0] f);
        return '{8'h01, 8'h10, 8'h01, f[15:8], f[7:0], 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    endfunction

    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk(baud_code, 16'h0180);
        chk(gate_value, 16'h0000);
        chk({14'h0, ranging_mode}, 16'h0000);
        for (int k = 0; k < 2; k++) begin
            self_ok = (k == 1);
            self_st = ~self_st;
            self_tp = self_tp + 8'h21;
            exchange(`RSCU_CMD_SELFTEST, 16'h0000, self_pay(k ? 8'h03 : 8'hFF, 16'h0180));
        end
        send_cmd(`RSCU_CMD_GATE, 16'h0100, 8'h00);
        chk(gate_value, 16'h0100);
        send_cmd(`RSCU_CMD_GATE, 16'h0300, 8'h01);
        chk(gate_value, 16'h0100);
        starts = 0;
        exchange(`RSCU_CMD_SINGLE, 16'h0000, range_pay(16'h0000));
        chk(16'(starts), 16'h0001);
        send_cmd(`RSCU_CMD_GATE, 16'h0000, 8'h00);
        exchange(`RSCU_CMD_SINGLE, 16'h0000, range_pay(16'h0080));
        for (int k = 0; k < 2; k++) begin
            exchange(k ? `RSCU_CMD_RUN_1HZ : `RSCU_CMD_RUN_5HZ, 16'h0000, range_pay(16'h0080));
            chk({14'h0, ranging_mode}, k ? 16'h0001 : 16'h0002);
            starts = 0;
            repeat (4 * (k ? P1 : P5)) @(negedge clk);
            chk(16'(starts), 16'h0004);
            send_cmd(`RSCU_CMD_STOP, 16'h0000, 8'h00);
            chk({14'h0, ranging_mode}, 16'h0000);
            idle();
        end
        for (int k = 0; k < 4; k++) begin
            exchange(`RSCU_CMD_BAUD, codes[k], '{8'h01, 8'h19, 8'h00, 8'h01, 8'h00, 8'h00, codes[k][15:8],
                codes[k][7:0], 8'h00, 8'h00, 8'h00, 8'h00});
            chk(baud_code, codes[k]);
            idle();
            div = divs[k];
            self_ex = ~self_ex;
            exchange(`RSCU_CMD_SELFTEST, 16'h0000, self_pay(8'h03, codes[k]));
        end
        send_cmd(`RSCU_CMD_BAUD, 16'h1234, 8'h00);
        repeat (16) @(negedge clk);
        chk(baud_code, 16'h0180);
        chk({15'h0, tx_busy}, 16'h0000);
        summarize();
    end
endmodule // rangefinder_serial_command_unit_bench
